// ---- verilog/ddrg_device.sv ----
// Purpose: Device-side command, power and burst data logic of a quad-bank DDR graphics DRAM.
// Assumes: clk is at least eight times the link clock; pins pass the sampler first.
// Notes: Data pins are split into in, out and enable; sequential burst order only.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Commands are taken only on the rising crossing of the clock pair.
// - Write data is captured on both edges of the incoming strobe.
// - Read data is launched on both clock crossings and both strobe edges.
// - Device drives the strobe for reads, controller drives it for writes.
// - Read strobe edges coincide with data changes; write strobe sits mid-window.
// - Read data and strobe transitions are aligned to clock crossings.
// - Array words are two data widths; pins carry halves per half cycle.
// - Burst length is selectable as 2, 4 or 8 locations.
// - A burst starts at the given column and follows the burst sequence.
// - Activate picks bank and row; read or write picks bank and column.
// - Four banks operate independently and can overlap.
// - Auto precharge closes the row on its own when the burst ends.
// - Clock gate high runs drivers and buffers; low turns them off.
// - Clock gate low gives precharge power-down or self refresh, else active power-down.
// - Clock gate sampled on entry and power-down exit; self refresh exit needs no clock.
// - Power-down keeps clock and gate inputs; self refresh keeps only the gate.
// - Any command taken while chip select is high is ignored.
// - Chip select is part of every command code.
// - Row strobe, column strobe, write enable and select encode the command.
// - A write beat is dropped when the write mask is high on that edge.
// - Precharge closes the selected bank, or all banks when the bit is set.
module ddrg_device (
   input wire logic clk,
   input wire logic rst,
   input wire logic ck,
   input wire logic ck_n,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic [ddrg_pkg::BA_W-1:0] bank_select,
   input wire logic [ddrg_pkg::ADDR_W-1:0] addr,
   input wire logic write_mask,
   input wire logic [1:0] burst_len_sel,
   input wire logic [ddrg_pkg::DQ_W-1:0] dq_in,
   output logic [ddrg_pkg::DQ_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic dqs_in,
   output logic dqs_out,
   output logic dqs_oe,
   output logic [1:0] power_mode,
   output logic [ddrg_pkg::NBANK-1:0] bank_open
);
   localparam int DW = ddrg_pkg::DQ_W;
   localparam int BW = ddrg_pkg::BA_W;
   localparam int RW = ddrg_pkg::ROW_W;
   localparam int CW = ddrg_pkg::COL_W;
   localparam int NB = ddrg_pkg::NBANK;
   localparam int IW = BW + RW + CW - 1;
   localparam int NWORD = 2 ** IW;
   localparam logic [1:0] RD_WAIT = 2'(ddrg_pkg::CAS_LAT - 1);
   typedef struct packed {
      logic ck_hi;
      logic dqs_prev;
      ddrg_pkg::ddrg_pwr_e pwr;
      logic [NB-1:0] open;
      logic [NB-1:0][RW-1:0] row;
      logic rd_go;
      logic rd_run;
      logic [1:0] rd_wait;
      logic [BW-1:0] rd_bank;
      logic [RW-1:0] rd_row;
      logic [CW-1:0] rd_col;
      logic [3:0] rd_cnt;
      logic [3:0] rd_bl;
      logic rd_ap;
      logic wr_go;
      logic [BW-1:0] wr_bank;
      logic [RW-1:0] wr_row;
      logic [CW-1:0] wr_col;
      logic [3:0] wr_cnt;
      logic [3:0] wr_bl;
      logic wr_ap;
      logic [DW-1:0] dq_out;
      logic dq_oe;
      logic dqs_out;
      logic dqs_oe;
   } ddrg_state_s;

   function automatic logic [3:0] cmd_of(input ddrg_pkg::ddrg_pins_s s);
      cmd_of = {s.cs_n, s.ras_n, s.cas_n, s.we_n};
   endfunction

   function automatic logic [3:0] bl_words(input logic [1:0] sel);
      case (sel)
         ddrg_pkg::BL_SEL_4: bl_words = ddrg_pkg::LEN_4;
         ddrg_pkg::BL_SEL_8: bl_words = ddrg_pkg::LEN_8;
         default: bl_words = ddrg_pkg::LEN_2;
      endcase
   endfunction

   function automatic logic [CW-1:0] burst_col(input logic [CW-1:0] start,
         input logic [3:0] i, input logic [3:0] bl);
      logic [CW-1:0] m;
      m = CW'(bl - 4'h1);
      burst_col = (start & ~m) | ((start + CW'(i)) & m);
   endfunction

   function automatic logic [IW-1:0] mem_idx(input logic [BW-1:0] b,
         input logic [RW-1:0] r, input logic [CW-1:0] c);
      mem_idx = {b, r, c[CW-1:1]};
   endfunction

   ddrg_pkg::ddrg_pins_s raw;
   ddrg_pkg::ddrg_pins_s p;
   ddrg_pin_if pin_bus ();
   ddrg_state_s q;
   ddrg_state_s next_q;
   logic [2*DW-1:0] mem [NWORD];
   logic [3:0] cmd;
   logic rise;
   logic fall;
   logic live;
   logic dqs_edge;
   logic wr_fire;
   logic wr_keep;
   logic [CW-1:0] rd_c;
   logic [CW-1:0] wr_c;
   logic [IW-1:0] rd_idx;
   logic [IW-1:0] wr_idx;
   logic [DW-1:0] rd_half;

   assign raw = {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, bank_select, addr,
      write_mask, burst_len_sel, dqs_in, dq_in};

   ddrg_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .raw(raw),
      .sync(pin_bus)
   );

   assign p = pin_bus.pins;
   assign cmd = cmd_of(p);
   // Crossings of the pair, not single-ended edges
   assign rise = p.ck & ~p.ck_n & ~q.ck_hi;
   assign fall = ~p.ck & p.ck_n & q.ck_hi;
   assign live = rise && q.pwr == ddrg_pkg::PW_ACTIVE && p.cke;
   assign dqs_edge = p.dqs ^ q.dqs_prev;
   assign wr_fire = q.wr_go && dqs_edge && q.pwr == ddrg_pkg::PW_ACTIVE;
   assign wr_keep = wr_fire && !p.write_mask;
   assign rd_c = burst_col(q.rd_col, q.rd_cnt, q.rd_bl);
   assign rd_idx = mem_idx(q.rd_bank, q.rd_row, rd_c);
   assign rd_half = rd_c[0] ? mem[rd_idx][2*DW-1:DW] : mem[rd_idx][DW-1:0];
   assign wr_c = burst_col(q.wr_col, q.wr_cnt, q.wr_bl);
   assign wr_idx = mem_idx(q.wr_bank, q.wr_row, wr_c);

   always_comb begin
      next_q = q;
      if (rise) begin
         next_q.ck_hi = 1'h1;
      end else if (fall) begin
         next_q.ck_hi = 1'h0;
      end
      next_q.dqs_prev = p.dqs;
      if (wr_fire) begin
         next_q.wr_cnt = q.wr_cnt + 4'h1;
         if (q.wr_cnt == q.wr_bl - 4'h1) begin
            next_q.wr_go = 1'h0;
            if (q.wr_ap) begin
               next_q.open[q.wr_bank] = 1'h0;
            end
         end
      end
      // Read launch follows both crossings of the clock
      if (q.rd_go && q.pwr == ddrg_pkg::PW_ACTIVE && (rise || fall)) begin
         if (q.rd_run) begin
            if (q.rd_cnt == q.rd_bl) begin
               next_q.rd_go = 1'h0;
               next_q.rd_run = 1'h0;
               next_q.dq_oe = 1'h0;
               next_q.dqs_oe = 1'h0;
               next_q.dqs_out = 1'h0;
               if (q.rd_ap) begin
                  next_q.open[q.rd_bank] = 1'h0;
               end
            end else begin
               next_q.dq_out = rd_half;
               next_q.dqs_out = rise;
               next_q.rd_cnt = q.rd_cnt + 4'h1;
            end
         end else if (rise) begin
            if (q.rd_wait != 2'h0) begin
               next_q.rd_wait = q.rd_wait - 2'h1;
               if (q.rd_wait == 2'h1) begin
                  next_q.dqs_oe = 1'h1;
                  next_q.dqs_out = 1'h0;
               end
            end else begin
               next_q.rd_run = 1'h1;
               next_q.dq_oe = 1'h1;
               next_q.dqs_oe = 1'h1;
               next_q.dqs_out = 1'h1;
               next_q.dq_out = rd_half;
               next_q.rd_cnt = 4'h1;
            end
         end
      end
      // Power states; commands decode only when fully awake
      if (rise) begin
         case (q.pwr)
            ddrg_pkg::PW_ACTIVE: begin
               if (!p.cke) begin
                  if (cmd == ddrg_pkg::CMD_REF && !(|q.open)) begin
                     next_q.pwr = ddrg_pkg::PW_SELF_REF;
                  end else if (|q.open) begin
                     next_q.pwr = ddrg_pkg::PW_ACT_PD;
                  end else begin
                     next_q.pwr = ddrg_pkg::PW_PRE_PD;
                  end
               end
            end
            ddrg_pkg::PW_PRE_PD, ddrg_pkg::PW_ACT_PD: begin
               if (p.cke) begin
                  next_q.pwr = ddrg_pkg::PW_ACTIVE;
               end
            end
            default: begin
            end
         endcase
      end
      if (live) begin
         // Select high yields codes above NOP, all ignored
         case (cmd)
            ddrg_pkg::CMD_ACT: begin
               next_q.open[p.ba] = 1'h1;
               next_q.row[p.ba] = p.addr[RW-1:0];
            end
            ddrg_pkg::CMD_READ: begin
               // Closed bank means no activate came first
               if (q.open[p.ba] && !q.rd_go && !q.wr_go) begin
                  next_q.rd_go = 1'h1;
                  next_q.rd_run = 1'h0;
                  next_q.rd_wait = RD_WAIT;
                  next_q.rd_bank = p.ba;
                  next_q.rd_row = q.row[p.ba];
                  next_q.rd_col = p.addr[CW-1:0];
                  next_q.rd_cnt = 4'h0;
                  next_q.rd_bl = bl_words(p.blen);
                  next_q.rd_ap = p.addr[ddrg_pkg::AP_BIT];
               end
            end
            ddrg_pkg::CMD_WRITE: begin
               if (q.open[p.ba] && !q.rd_go && !q.wr_go) begin
                  next_q.wr_go = 1'h1;
                  next_q.wr_bank = p.ba;
                  next_q.wr_row = q.row[p.ba];
                  next_q.wr_col = p.addr[CW-1:0];
                  next_q.wr_cnt = 4'h0;
                  next_q.wr_bl = bl_words(p.blen);
                  next_q.wr_ap = p.addr[ddrg_pkg::AP_BIT];
               end
            end
            ddrg_pkg::CMD_PRE: begin
               if (p.addr[ddrg_pkg::ALL_BANKS_BIT]) begin
                  next_q.open = '0;
               end else begin
                  next_q.open[p.ba] = 1'h0;
               end
            end
            default: begin
            end
         endcase
      end
      if (q.pwr == ddrg_pkg::PW_SELF_REF && p.cke) begin
         next_q.pwr = ddrg_pkg::PW_ACTIVE;
      end
      // Drivers off whenever the next power state is not active
      if (next_q.pwr != ddrg_pkg::PW_ACTIVE) begin
         next_q.dq_oe = 1'h0;
         next_q.dqs_oe = 1'h0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   always_ff @(posedge clk) begin
      if (wr_keep) begin
         if (wr_c[0]) begin
            mem[wr_idx][2*DW-1:DW] <= p.dq;
         end else begin
            mem[wr_idx][DW-1:0] <= p.dq;
         end
      end
   end

   assign dq_out = q.dq_out;
   assign dq_oe = q.dq_oe;
   assign dqs_out = q.dqs_out;
   assign dqs_oe = q.dqs_oe;
   assign power_mode = q.pwr;
   assign bank_open = q.open;

   localparam int LAT_MIN = 25;
   localparam int LAT_MAX = 35;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_act_opens: assert property (
      live && cmd == ddrg_pkg::CMD_ACT |=> q.open[$past(p.ba)])
      else $error("activate did not open bank");
   a_cs_masks: assert property (
      live && p.cs_n && !q.rd_go && !q.wr_go |=> bank_open == $past(bank_open))
      else $error("deselected command changed banks");
   a_pre_all: assert property (
      live && cmd == ddrg_pkg::CMD_PRE && p.addr[ddrg_pkg::ALL_BANKS_BIT]
      && !q.rd_go && !q.wr_go |=> bank_open == '0)
      else $error("precharge all left a bank open");
   a_read_latency: assert property (
      $rose(q.rd_go) |-> ##[LAT_MIN:LAT_MAX] $rose(q.dq_oe))
      else $error("read data late or missing");
   a_dqs_aligned: assert property (
      q.dq_oe && $changed(q.dq_out) |-> $changed(q.dqs_out))
      else $error("read data moved without strobe edge");
   a_drv_off_pd: assert property (
      q.pwr != ddrg_pkg::PW_ACTIVE |-> !dq_oe && !dqs_oe)
      else $error("drivers on while clock gate low");
   a_sr_exit: assert property (
      q.pwr == ddrg_pkg::PW_SELF_REF && p.cke |=> q.pwr == ddrg_pkg::PW_ACTIVE)
      else $error("self refresh exit not immediate");
   a_pd_entry: assert property (
      rise && q.pwr == ddrg_pkg::PW_ACTIVE && !p.cke && (|q.open)
      |=> q.pwr == ddrg_pkg::PW_ACT_PD)
      else $error("active power-down not entered");
   a_ap_close: assert property (
      $fell(q.rd_go) && q.rd_ap |-> !q.open[q.rd_bank])
      else $error("auto precharge left row open");
   a_wr_beats: assert property (
      $fell(q.wr_go) |-> q.wr_cnt == q.wr_bl)
      else $error("write burst beat count wrong");

   c_read: cover property ($fell(q.rd_run));
   c_write: cover property ($fell(q.wr_go));
   c_self_ref: cover property (q.pwr == ddrg_pkg::PW_SELF_REF);
   c_act_pd: cover property (q.pwr == ddrg_pkg::PW_ACT_PD);
endmodule
`default_nettype wire

// ---- pkg/ddrg_pkg.sv ----
// Purpose: Shared constants and types for the graphics DDR device interface.
// Assumes: Pins are sampled by a core clock several times faster than the link clock.
// Notes: Array dimensions are kept small so the model stays light in simulation.
package ddrg_pkg;
   localparam int DQ_W = 16;
   localparam int BA_W = 2;
   localparam int ADDR_W = 13;
   localparam int ROW_W = 4;
   localparam int COL_W = 4;
   localparam int NBANK = 4;
   localparam int AP_BIT = 10;
   localparam int ALL_BANKS_BIT = 10;
   localparam int CAS_LAT = 3;
   // Command code is {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WRITE = 4'h4;
   localparam logic [3:0] CMD_READ = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   localparam logic [1:0] BL_SEL_4 = 2'h2;
   localparam logic [1:0] BL_SEL_8 = 2'h3;
   localparam logic [3:0] LEN_2 = 4'h2;
   localparam logic [3:0] LEN_4 = 4'h4;
   localparam logic [3:0] LEN_8 = 4'h8;
   typedef enum logic [1:0] {PW_ACTIVE, PW_PRE_PD, PW_ACT_PD, PW_SELF_REF} ddrg_pwr_e;
   typedef struct packed {
      logic ck;
      logic ck_n;
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [BA_W-1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic write_mask;
      logic [1:0] blen;
      logic dqs;
      logic [DQ_W-1:0] dq;
   } ddrg_pins_s;
endpackage

// ---- pkg/ddrg_pin_if.sv ----
// Purpose: Carries the synchronised pin bundle from the sampler to the device core.
// Assumes: One producer, one consumer.
// Notes: Levels only; edges are found by the consumer.
`timescale 1ns/1ps
`default_nettype none
interface ddrg_pin_if;
   ddrg_pkg::ddrg_pins_s pins;
   modport src (output pins);
   modport dst (input pins);
endinterface
`default_nettype wire

// ---- verilog/ddrg_pin_sync.sv ----
// Purpose: Three-stage sampler for every pin entering the core clock domain.
// Assumes: Pins are asynchronous to clk.
// Notes: A bit changes only once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module ddrg_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire ddrg_pkg::ddrg_pins_s raw,
   ddrg_pin_if.src sync
);
   localparam int PW = $bits(ddrg_pkg::ddrg_pins_s);
   typedef struct packed {
      logic [PW-1:0] s1;
      logic [PW-1:0] s2;
      logic [PW-1:0] s3;
      logic [PW-1:0] agreed;
   } ddrg_sync_s;
   ddrg_sync_s q;
   ddrg_sync_s next_q;
   always_comb begin
      logic [PW-1:0] diff;
      diff = q.s2 ^ q.s3;
      next_q = q;
      next_q.s1 = raw;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      next_q.agreed = (q.s2 & ~diff) | (q.agreed & diff);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end
   assign sync.pins = q.agreed;
endmodule
`default_nettype wire

// ---- test/ddrg_ctrl_model.sv ----
// Purpose: Controller model for the link clock, command pins and write bursts.
// Assumes: Link clock of 80 ns that runs free while run is high.
// Notes: Command pins change on the falling link edge; dq and strobe are driven only in writes.
`timescale 1ns/1ps
`default_nettype none
module ddrg_ctrl_model (
   output logic ck,
   output logic ck_n,
   output logic cke,
   output logic [3:0] code,
   output logic [ddrg_pkg::BA_W-1:0] bank_select,
   output logic [ddrg_pkg::ADDR_W-1:0] addr,
   output logic write_mask,
   output logic [ddrg_pkg::DQ_W-1:0] dq,
   output logic dqs,
   output logic drive
);
   logic run = 1'b1;
   assign ck_n = ~ck;
   initial begin
      ck = 1'b0;
      cke = 1'b1;
      code = ddrg_pkg::CMD_NOP;
      bank_select = '0;
      addr = '0;
      write_mask = 1'b0;
      dq = '0;
      dqs = 1'b0;
      drive = 1'b0;
      #3.3;
      forever begin
         #40;
         // Stops only once low
         if (run || ck)
            ck = ~ck;
      end
   end
   task automatic cmd(input logic [3:0] c, input logic [ddrg_pkg::BA_W-1:0] b,
                      input logic [ddrg_pkg::ADDR_W-1:0] a, input logic g);
      @(negedge ck);
      cke = g;
      code = c;
      bank_select = b;
      addr = a;
      @(negedge ck);
      code = ddrg_pkg::CMD_NOP;
      bank_select = ~b;
      addr = ~a;
   endtask
   task automatic wr(input logic [ddrg_pkg::BA_W-1:0] b, input logic [ddrg_pkg::ADDR_W-1:0] a,
                     input int n, input logic [ddrg_pkg::DQ_W-1:0] d [8], input logic [7:0] m);
      drive = 1'b1;
      dqs = 1'b0;
      cmd(ddrg_pkg::CMD_WRITE, b, a, 1'b1);
      for (int i = 0; i < n; i++) begin
         #20;
         dq = d[i];
         write_mask = m[i];
         #20;
         // Strobe edge mid data window
         dqs = ~dqs;
      end
      #20;
      drive = 1'b0;
      write_mask = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- test/test_ddrg_device.sv ----
// Purpose: Self-checking bench for the graphics DDR device logic.
// Assumes: Controller model drives the link pins; link clock 80 ns.
// Notes: Read words are checked against a queue filled by the read task.
`timescale 1ns/1ps
`default_nettype none
module test_ddrg_device;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic flt = 1'b0;
   logic prev = 1'b0;
   logic [1:0] bl_sel = 2'h0;
   logic ck, ck_n, cke, wmask, c_dqs, drive, dq_oe, dqs_out, dqs_oe;
   logic [3:0] code, bopen;
   logic [1:0] ba, pmode;
   logic [12:0] addr;
   logic [15:0] c_dq, dq_out, pdq;
   logic [15:0] exp_q [$];
   logic [15:0] mem [logic [9:0]];
   logic [3:0] row_of [4];
   int fails = 0;
   int compares = 0;
   // Undriven lines wander every cycle
   wire logic [15:0] dq_w = dq_oe ? dq_out : drive ? c_dq : {16{flt}};
   wire logic dqs_w = dqs_oe ? dqs_out : drive ? c_dqs : flt;
   always #4 clk = ~clk;
   always @(posedge clk) flt <= ~flt;
   ddrg_ctrl_model ddrg_ctrl_model_i (.ck(ck), .ck_n(ck_n), .cke(cke), .code(code),
      .bank_select(ba), .addr(addr), .write_mask(wmask), .dq(c_dq), .dqs(c_dqs),
      .drive(drive));
   ddrg_device ddrg_device_i (.clk(clk), .rst(rst), .ck(ck), .ck_n(ck_n), .cke(cke),
      .cs_n(code[3]), .ras_n(code[2]), .cas_n(code[1]), .we_n(code[0]),
      .bank_select(ba), .addr(addr), .write_mask(wmask), .burst_len_sel(bl_sel),
      .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_w), .dqs_out(dqs_out),
      .dqs_oe(dqs_oe), .power_mode(pmode), .bank_open(bopen));
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic wait_ck(input int n);
      repeat (n) @(negedge ck);
      @(posedge clk);
      #1;
   endtask
   function automatic logic [9:0] loc(input logic [1:0] b, input logic [3:0] c, input int n,
                                      input int i);
      logic [3:0] w;
      w = 4'(n - 1);
      return {b, row_of[b], (c & ~w) | ((c + 4'(i)) & w)};
   endfunction
   function automatic logic [1:0] blsel(input int n);
      if (n == 8)
         return ddrg_pkg::BL_SEL_8;
      if (n == 4)
         return ddrg_pkg::BL_SEL_4;
      return 2'($urandom_range(1, 0));
   endfunction
   task automatic rd(input logic [1:0] b, input logic [3:0] c, input int n, input logic ap);
      for (int i = 0; i < n; i++)
         exp_q.push_back(mem[loc(b, c, n, i)]);
      bl_sel = blsel(n);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_READ, b, {2'h0, ap, 6'h00, c}, 1'b1);
      wait_ck(n / 2 + 4);
   endtask
   task automatic wr(input logic [1:0] b, input logic [3:0] c, input int n, input logic ap,
                     input logic [7:0] m);
      logic [15:0] d [8];
      for (int i = 0; i < 8; i++) begin
         d[i] = 16'($urandom);
         if (i < n && m[i] == 1'b0)
            mem[loc(b, c, n, i)] = d[i];
      end
      bl_sel = blsel(n);
      ddrg_ctrl_model_i.wr(b, {2'h0, ap, 6'h00, c}, n, d, m);
      wait_ck(1);
   endtask
   task automatic status(input logic [3:0] bo, input logic [1:0] pm);
      wait_ck(1);
      check("bank_open", 16'(bo), 16'(bopen));
      check("power_mode", 16'(pm), 16'(pmode));
      check("drivers_on", 16'h0000, 16'({dq_oe, dqs_oe}));
   endtask
   // Each strobe toggle carries the next word; data holds in between
   always @(negedge clk) begin
      if (dq_oe === 1'b1 && dqs_out !== prev) begin
         // An unexpected word always mismatches
         check("dq_out", exp_q.size() > 0 ? exp_q.pop_front() : ~dq_out, dq_out);
         check("dqs_oe", 16'h0001, 16'(dqs_oe));
      end else if (dq_oe === 1'b1 && dq_out !== pdq)
         check("dq_hold", pdq, dq_out);
      prev = dqs_out;
      pdq = dq_out;
   end
   initial begin
      void'($urandom(32'hb053));
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      wait_ck(2);
      status(4'h0, 2'h0);
      for (int b = 0; b < 4; b++) begin
         row_of[b] = 4'(b + 3);
         ddrg_ctrl_model_i.cmd(4'hB, 2'(b), 13'(b + 3), 1'b1);
         status(4'((1 << b) - 1), 2'h0);
         ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_ACT, 2'(b), 13'(b + 3), 1'b1);
         status(4'((1 << (b + 1)) - 1), 2'h0);
      end
      wr(2'h0, 4'h0, 8, 1'b0, 8'h00);
      wr(2'h0, 4'h5, 4, 1'b0, 8'h02);
      rd(2'h0, 4'h3, 8, 1'b0);
      wr(2'h1, 4'h9, 2, 1'b0, 8'h00);
      rd(2'h1, 4'h9, 2, 1'b1);
      status(4'hD, 2'h0);
      rd(2'h0, 4'h2, 4, 1'b1);
      status(4'hC, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_READ, 2'h0, 13'h0000, 1'b1);
      wait_ck(6);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0);
      status(4'hC, 2'h2);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_PRE, 2'h2, 13'h0400, 1'b0);
      status(4'hC, 2'h2);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1);
      status(4'hC, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_PRE, 2'h2, 13'h0000, 1'b1);
      status(4'h8, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_ACT, 2'h0, 13'h0003, 1'b1);
      status(4'h9, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_PRE, 2'h1, 13'h0400, 1'b1);
      status(4'h0, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_REF, 2'h0, 13'h0000, 1'b1);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b0);
      status(4'h0, 2'h1);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_ACT, 2'h1, 13'h0004, 1'b0);
      status(4'h0, 2'h1);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_NOP, 2'h0, 13'h0000, 1'b1);
      status(4'h0, 2'h0);
      ddrg_ctrl_model_i.cmd(ddrg_pkg::CMD_REF, 2'h0, 13'h0000, 1'b0);
      status(4'h0, 2'h3);
      ddrg_ctrl_model_i.run = 1'b0;
      #200;
      @(posedge clk);
      #1;
      ddrg_ctrl_model_i.cke = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      check("power_mode", 16'h0000, 16'(pmode));
      ddrg_ctrl_model_i.run = 1'b1;
      wait_ck(2);
      check("words_left", 16'h0000, 16'(exp_q.size()));
      stop_test();
   end
   initial begin
      #150000;
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
